/* xdm_map.vh */
// Register map, field layout, reset values and timing counts of the data memory interface
`ifndef XDM_MAP_VH
`define XDM_MAP_VH
`define XDM_AXI_AW        12
// Register indices; byte address is four times the index
`define XDM_IDX_TIMING    10'h0a1
`define XDM_IDX_PAGE      10'h0a2
`define XDM_IDX_CONFIG    10'h0a3
`define XDM_IDX_STATUS    10'h0a4
// Reset values
`define XDM_RST_TIMING    8'hff
`define XDM_RST_PAGE      8'h00
`define XDM_RST_CONFIG    6'h03
// Config fields
`define XDM_CFG_ALEW_LSB  0
`define XDM_CFG_MODE_LSB  2
`define XDM_CFG_MUXSEL    4
`define XDM_CFG_PORT_GROUP_SELECT    5
`define XDM_CFG_WIDTH     6
// Timing fields
`define XDM_TC_HOLD_LSB   0
`define XDM_TC_STRB_LSB   2
`define XDM_TC_SETUP_LSB  6
// Memory map modes
`define XDM_MODE_INT      2'b00
`define XDM_MODE_SPLIT    2'b01
`define XDM_MODE_BANK     2'b10
`define XDM_MODE_EXT      2'b11
// On-chip RAM: 4 kB, address top nibble zero means on-chip in split modes
`define XDM_RAM_AW        12
`define XDM_RAM_WORDS     4096
// Tail of an off-chip access; with the start cycle this is the fixed overhead of 4
`define XDM_TAIL_CNT      4'd2
// Responses
`define XDM_RESP_OKAY     2'b00
`define XDM_RESP_SLVERR   2'b10
`endif

/* xdm_mem_if.v */
// External data memory interface with on-chip RAM and AXI4-Lite registers
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/10ps
`include "xdm_map.vh"
module xdm_mem_if (
  input  wire                    clock,
  input  wire                    sys_rst,
  // AXI4-Lite slave
  input  wire [`XDM_AXI_AW-1:0]  s_axi_awaddr,
  input  wire                    s_axi_awvalid,
  output wire                    s_axi_awready,
  input  wire [31:0]             s_axi_wdata,
  input  wire [3:0]              s_axi_wstrb,
  input  wire                    s_axi_wvalid,
  output wire                    s_axi_wready,
  output reg  [1:0]              s_axi_bresp,
  output reg                     s_axi_bvalid,
  input  wire                    s_axi_bready,
  input  wire [`XDM_AXI_AW-1:0]  s_axi_araddr,
  input  wire                    s_axi_arvalid,
  output wire                    s_axi_arready,
  output reg  [31:0]             s_axi_rdata,
  output reg  [1:0]              s_axi_rresp,
  output reg                     s_axi_rvalid,
  input  wire                    s_axi_rready,
  // Core data memory move requests
  input  wire                    req_valid,
  output wire                    req_ready,
  input  wire                    req_write,
  input  wire                    req_wide,
  input  wire [15:0]             req_data_pointer,
  input  wire [7:0]              req_low_byte,
  input  wire [7:0]              req_wdata,
  output reg                     resp_valid,
  output reg  [7:0]              resp_rdata,
  // External pins, shared values; enables per port group (0: low, 1: high)
  output wire                    pin_ale,
  output wire                    pin_rd_n,
  output wire                    pin_wr_n,
  output wire [7:0]              pin_addr_hi,
  output wire [7:0]              pin_addr_lo,
  output wire [7:0]              pin_data_out,
  input  wire [7:0]              pin_data_in_lo,
  input  wire [7:0]              pin_data_in_hi,
  output wire [1:0]              ctl_oe_n,
  output wire [1:0]              addr_hi_oe_n,
  output wire [1:0]              addr_lo_oe_n,
  output wire [1:0]              data_oe_n
);

  localparam [3:0] ST_IDLE  = 4'd0;
  localparam [3:0] ST_START = 4'd1;
  localparam [3:0] ST_ALEH  = 4'd2;
  localparam [3:0] ST_ALEL  = 4'd3;
  localparam [3:0] ST_SETUP = 4'd4;
  localparam [3:0] ST_STRB  = 4'd5;
  localparam [3:0] ST_HOLD  = 4'd6;
  localparam [3:0] ST_TAIL  = 4'd7;
  // Registers
  reg  [7:0]                  timing_q;
  reg  [7:0]                  page_q;
  reg  [`XDM_CFG_WIDTH-1:0]   config_q;
  reg                         last_off_q;
  reg                         last_wr_q;
  // AXI write side
  reg                         aw_have_q;
  reg                         w_have_q;
  reg  [`XDM_AXI_AW-1:0]      aw_addr_q;
  reg  [7:0]                  w_byte_q;
  reg                         w_lane0_q;
  // Access engine
  reg  [3:0]                  state_q;
  reg  [3:0]                  state_d;
  reg  [3:0]                  cnt_q;
  reg  [3:0]                  cnt_d;
  reg  [15:0]                 acc_addr_q;
  reg  [7:0]                  acc_wdata_q;
  reg                         acc_wr_q;
  reg                         acc_mux_q;
  reg                         acc_grp_q;
  reg                         acc_hi_q;
  reg  [7:0]                  din_s1_q;
  reg  [7:0]                  din_s2_q;
  reg  [7:0]                  din_s3_q;
  reg                         rd_end_q;
  reg                         rd_end1_q;
  reg                         rd_end2_q;
  reg  [7:0]                  ram [0:`XDM_RAM_WORDS-1];
  wire [1:0]  cfg_mode  = config_q[`XDM_CFG_MODE_LSB +: 2];
  wire        cfg_nomux = config_q[`XDM_CFG_MUXSEL];
  wire        cfg_grp   = config_q[`XDM_CFG_PORT_GROUP_SELECT];
  wire [1:0]  cfg_alew  = config_q[`XDM_CFG_ALEW_LSB +: 2];
  wire [1:0]  tc_setup  = timing_q[`XDM_TC_SETUP_LSB +: 2];
  wire [3:0]  tc_strb   = timing_q[`XDM_TC_STRB_LSB +: 4];
  wire [1:0]  tc_hold   = timing_q[`XDM_TC_HOLD_LSB +: 2];
  function reg_hit;
    input [`XDM_AXI_AW-1:0] addr;
    input [9:0]             idx;
    begin
      reg_hit = (addr[`XDM_AXI_AW-1:2] == idx);
    end
  endfunction
  // Enter setup phase, skipping it when programmed to zero
  function [7:0] go_setup;
    input [1:0] setup;
    input [3:0] strb;
    begin
      if (setup == 2'd0) begin
        go_setup = {ST_STRB, strb};
      end else begin
        go_setup = {ST_SETUP, 2'b00, setup - 2'd1};
      end
    end
  endfunction
  // Enter hold phase, skipping it when programmed to zero
  function [7:0] go_hold;
    input [1:0] hold;
    begin
      if (hold == 2'd0) begin
        go_hold = {ST_TAIL, `XDM_TAIL_CNT};
      end else begin
        go_hold = {ST_HOLD, 2'b00, hold - 2'd1};
      end
    end
  endfunction
  // ---------------- Address decode of a request ----------------
  wire [15:0] eff_addr = req_wide ? req_data_pointer : {page_q, req_low_byte};
  reg         req_off;
  reg         req_hi;
  always @* begin
    case (cfg_mode)
      `XDM_MODE_INT: begin
        req_off = 1'b0;
        req_hi  = 1'b0;
      end
      `XDM_MODE_SPLIT: begin
        req_off = (eff_addr[15:12] != 4'h0);
        req_hi  = req_wide;
      end
      `XDM_MODE_BANK: begin
        req_off = (eff_addr[15:12] != 4'h0);
        req_hi  = 1'b1;
      end
      default: begin
        req_off = 1'b1;
        req_hi  = req_wide;
      end
    endcase
  end
  // External mode never reads the page register for byte-pointer accesses
  wire [15:0] ext_addr = (cfg_mode == `XDM_MODE_EXT && !req_wide) ?
                         {8'h00, req_low_byte} : eff_addr;
  assign req_ready = (state_q == ST_IDLE) && !resp_valid;
  wire   req_take  = req_valid && req_ready;
  // ---------------- Access state machine ----------------
  always @* begin
    state_d = state_q;
    cnt_d   = (cnt_q == 4'd0) ? 4'd0 : cnt_q - 4'd1;
    case (state_q)
      ST_IDLE: begin
        if (req_take && req_off) begin
          state_d = ST_START;
          cnt_d   = 4'd0;
        end
      end
      ST_START: begin
        if (!cfg_nomux) begin
          state_d = ST_ALEH;
          cnt_d   = {2'b00, cfg_alew};
        end else begin
          {state_d, cnt_d} = go_setup(tc_setup, tc_strb);
        end
      end
      ST_ALEH: begin
        if (cnt_q == 4'd0) begin
          state_d = ST_ALEL;
          cnt_d   = {2'b00, cfg_alew};
        end
      end
      ST_ALEL: begin
        if (cnt_q == 4'd0) begin
          {state_d, cnt_d} = go_setup(tc_setup, tc_strb);
        end
      end
      ST_SETUP: begin
        if (cnt_q == 4'd0) begin
          state_d = ST_STRB;
          cnt_d   = tc_strb;
        end
      end
      ST_STRB: begin
        if (cnt_q == 4'd0) begin
          {state_d, cnt_d} = go_hold(tc_hold);
        end
      end
      ST_HOLD: begin
        if (cnt_q == 4'd0) begin
          state_d = ST_TAIL;
          cnt_d   = `XDM_TAIL_CNT;
        end
      end
      ST_TAIL: begin
        if (cnt_q == 4'd0) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
        cnt_d   = 4'd0;
      end
    endcase
  end
  // Pin sampling: three stages; the capture point trails the strobe to match
  always @(posedge clock) begin
    din_s1_q <= acc_grp_q ? pin_data_in_hi : pin_data_in_lo;
    din_s2_q <= din_s1_q;
    din_s3_q <= din_s2_q;
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      state_q     <= ST_IDLE;
      cnt_q       <= 4'd0;
      acc_addr_q  <= 16'h0000;
      acc_wdata_q <= 8'h00;
      acc_wr_q    <= 1'b0;
      acc_mux_q   <= 1'b0;
      acc_grp_q   <= 1'b0;
      acc_hi_q    <= 1'b0;
      rd_end_q    <= 1'b0;
      rd_end1_q   <= 1'b0;
      rd_end2_q   <= 1'b0;
      resp_valid  <= 1'b0;
      resp_rdata  <= 8'h00;
      last_off_q  <= 1'b0;
      last_wr_q   <= 1'b0;
    end else begin
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      rd_end_q   <= (state_q == ST_STRB) && (cnt_q == 4'd0) && !acc_wr_q;
      rd_end1_q  <= rd_end_q;
      rd_end2_q  <= rd_end1_q;
      resp_valid <= 1'b0;
      // Pin state at the last strobe cycle reaches the third stage here
      if (rd_end2_q) begin
        resp_rdata <= din_s3_q;
      end
      if (req_take) begin
        acc_addr_q  <= ext_addr;
        acc_wdata_q <= req_wdata;
        acc_wr_q    <= req_write;
        // Pin usage is frozen for the whole access
        acc_mux_q   <= !cfg_nomux;
        acc_grp_q   <= cfg_grp;
        acc_hi_q    <= req_hi;
        last_off_q  <= req_off;
        last_wr_q   <= req_write;
        if (!req_off) begin
          resp_valid <= 1'b1;
          if (!req_write) begin
            resp_rdata <= ram[eff_addr[`XDM_RAM_AW-1:0]];
          end
        end
      end
      if (state_q == ST_TAIL && cnt_q == 4'd0) begin
        resp_valid <= 1'b1;
      end
    end
  end
  // On-chip RAM; high address bits dropped so the space wraps every 4 kB
  always @(posedge clock) begin
    if (req_take && !req_off && req_write) begin
      ram[eff_addr[`XDM_RAM_AW-1:0]] <= req_wdata;
    end
  end
  // ---------------- Pin drive ----------------
  wire claim    = (state_q != ST_IDLE);
  wire addr_ph  = acc_mux_q && (state_q == ST_START || state_q == ST_ALEH ||
                                state_q == ST_ALEL);
  wire [1:0] grp_on = claim ? (acc_grp_q ? 2'b10 : 2'b01) : 2'b00;
  assign pin_ale      = (state_q == ST_ALEH);
  assign pin_rd_n     = !((state_q == ST_STRB) && !acc_wr_q);
  assign pin_wr_n     = !((state_q == ST_STRB) && acc_wr_q);
  assign pin_addr_hi  = acc_addr_q[15:8];
  assign pin_addr_lo  = acc_addr_q[7:0];
  // Shared pins carry the address until the latch has closed
  assign pin_data_out = addr_ph ? acc_addr_q[7:0] : acc_wdata_q;

  assign ctl_oe_n     = ~grp_on;
  assign addr_hi_oe_n = ~(grp_on & {2{acc_hi_q}});
  assign addr_lo_oe_n = ~(grp_on & {2{!acc_mux_q}});
  assign data_oe_n    = ~(grp_on & {2{acc_wr_q || addr_ph}});

  // ---------------- AXI4-Lite slave ----------------
  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  wire wr_go     = aw_have_q && w_have_q;
  wire wr_timing = reg_hit(aw_addr_q, `XDM_IDX_TIMING);
  wire wr_page   = reg_hit(aw_addr_q, `XDM_IDX_PAGE);
  wire wr_config = reg_hit(aw_addr_q, `XDM_IDX_CONFIG);
  wire wr_status = reg_hit(aw_addr_q, `XDM_IDX_STATUS);

  always @(posedge clock) begin
    if (sys_rst) begin
      aw_have_q    <= 1'b0;
      w_have_q     <= 1'b0;
      aw_addr_q    <= {`XDM_AXI_AW{1'b0}};
      w_byte_q     <= 8'h00;
      w_lane0_q    <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `XDM_RESP_OKAY;
      timing_q     <= `XDM_RST_TIMING;
      page_q       <= `XDM_RST_PAGE;
      config_q     <= `XDM_RST_CONFIG;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q  <= 1'b1;
        w_byte_q  <= s_axi_wdata[7:0];
        w_lane0_q <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_timing || wr_page || wr_config || wr_status) ?
                        `XDM_RESP_OKAY : `XDM_RESP_SLVERR;
        if (w_lane0_q && wr_timing) begin
          timing_q <= w_byte_q;
        end
        if (w_lane0_q && wr_page) begin
          page_q <= w_byte_q;
        end
        if (w_lane0_q && wr_config) begin
          config_q <= w_byte_q[`XDM_CFG_WIDTH-1:0];
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `XDM_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `XDM_RESP_OKAY;
      if (reg_hit(s_axi_araddr, `XDM_IDX_TIMING)) begin
        s_axi_rdata <= {24'h00_0000, timing_q};
      end else if (reg_hit(s_axi_araddr, `XDM_IDX_PAGE)) begin
        s_axi_rdata <= {24'h00_0000, page_q};
      end else if (reg_hit(s_axi_araddr, `XDM_IDX_CONFIG)) begin
        s_axi_rdata <= {26'h000_0000, config_q};
      end else if (reg_hit(s_axi_araddr, `XDM_IDX_STATUS)) begin
        s_axi_rdata <= {29'h0000_0000, last_wr_q, last_off_q, claim};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `XDM_RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // xdm_mem_if

/* xdm_mem_if_props.sv */
// Concurrent checks on the pins and core handshake of the data memory interface
`timescale 1ns/10ps
module xdm_mem_if_props (
  input logic       clock,
  input logic       sys_rst,
  input logic       req_ready,
  input logic       resp_valid,
  input logic       pin_ale,
  input logic       pin_rd_n,
  input logic       pin_wr_n,
  input logic [1:0] ctl_oe_n,
  input logic [1:0] addr_hi_oe_n,
  input logic [1:0] addr_lo_oe_n,
  input logic [1:0] data_oe_n
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  wire claim = (ctl_oe_n != 2'b11);
  wire [1:0] any_en = ~data_oe_n | ~addr_hi_oe_n | ~addr_lo_oe_n;

  AST_IDLE_FREE: assert property (req_ready |-> !claim && any_en == 2'b00 && !pin_ale
    && pin_rd_n && pin_wr_n) else $error("pins claimed while idle");
  AST_RESP_FREE: assert property (resp_valid |-> !claim && !req_ready)
    else $error("pins still claimed at completion");
  AST_RD_RELEASE: assert property (!pin_rd_n |-> data_oe_n == 2'b11)
    else $error("data driven during read strobe");
  AST_WR_DRIVE: assert property (!pin_wr_n |-> data_oe_n != 2'b11 && pin_rd_n)
    else $error("write strobe without data drive");
  AST_ONE_GROUP: assert property (claim |-> ctl_oe_n != 2'b00 && (any_en & ctl_oe_n) == 2'b00)
    else $error("both port groups enabled");
  AST_ALE_QUIET: assert property (pin_ale |-> pin_rd_n && pin_wr_n && addr_lo_oe_n == 2'b11)
    else $error("strobe or low address pins during latch phase");
  AST_ALE_WIDTH: assert property ($rose(pin_ale) |-> ##[1:4] !pin_ale)
    else $error("latch enable high too long");
  AST_ALE_LOW: assert property ($fell(pin_ale) |-> claim && pin_rd_n && pin_wr_n)
    else $error("strobe without latch low phase");
  AST_MIN_LEN: assert property ($rose(claim) |-> !resp_valid [*5])
    else $error("off-chip access too short");
  AST_MAX_LEN: assert property ($rose(claim) |-> ##[5:41] resp_valid)
    else $error("off-chip access never completes");

  cover property ($rose(pin_ale));
  cover property (!pin_rd_n);
  cover property (!pin_wr_n);
endmodule // xdm_mem_if_props

bind xdm_mem_if xdm_mem_if_props u_props (.clock, .sys_rst, .req_ready, .resp_valid,
  .pin_ale, .pin_rd_n, .pin_wr_n, .ctl_oe_n, .addr_hi_oe_n, .addr_lo_oe_n, .data_oe_n);

/* xdm_mem_if_tb.sv */
// Self-checking bench for the data memory interface
`timescale 1ns/10ps
`include "xdm_map.vh"
module xdm_mem_if_tb;
  reg         clock, sys_rst, mux, grp;
  reg  [11:0] s_axi_awaddr, s_axi_araddr;
  reg  [31:0] s_axi_wdata;
  reg  [3:0]  s_axi_wstrb;
  reg         s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  reg         req_valid, req_write, req_wide;
  reg  [15:0] req_data_pointer;
  reg  [7:0]  req_low_byte, req_wdata, hv;
  wire        req_ready, resp_valid, pin_ale, pin_rd_n, pin_wr_n;
  wire [7:0]  resp_rdata, pin_addr_hi, pin_addr_lo, pin_data_out, pin_data_in_lo, pin_data_in_hi;
  wire [1:0]  ctl_oe_n, addr_hi_oe_n, addr_lo_oe_n, data_oe_n;
  reg  [1:0]  gm;
  reg  [31:0] rv;
  reg  [3:0]  wc;
  integer     bad_count, check_count, cl, sl, al, hen, k;
  localparam [11:0] A_TC = {`XDM_IDX_TIMING, 2'b00};
  localparam [11:0] A_PG = {`XDM_IDX_PAGE, 2'b00};
  localparam [11:0] A_CF = {`XDM_IDX_CONFIG, 2'b00};
  localparam [11:0] A_ST = {`XDM_IDX_STATUS, 2'b00};
  localparam [1:0]  OK = `XDM_RESP_OKAY;
  localparam [1:0]  ER = `XDM_RESP_SLVERR;

  xdm_mem_if uut (.clock, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .req_valid, .req_ready, .req_write, .req_wide, .req_data_pointer,
    .req_low_byte, .req_wdata, .resp_valid, .resp_rdata, .pin_ale, .pin_rd_n, .pin_wr_n,
    .pin_addr_hi, .pin_addr_lo, .pin_data_out, .pin_data_in_lo, .pin_data_in_hi, .ctl_oe_n,
    .addr_hi_oe_n, .addr_lo_oe_n, .data_oe_n);
  xdm_sram_model u_mem (.clock, .mux, .grp, .pin_ale, .pin_rd_n, .pin_wr_n, .pin_addr_hi,
    .pin_addr_lo, .pin_data_out, .addr_hi_oe_n, .pin_data_in_lo, .pin_data_in_hi);

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task results;
    begin
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask

  task chk(input [31:0] g, input [31:0] e);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        bad_count = bad_count + 1;
        $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask

  task wr(input [11:0] a, input [7:0] d, input [1:0] er);
    reg ta, tw, b;
    reg [1:0] r;
    begin
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      b = 1'b0;
      while (!b) begin
        @(negedge clock);
        ta = s_axi_awvalid && s_axi_awready;
        tw = s_axi_wvalid && s_axi_wready;
        b = s_axi_bvalid;
        r = s_axi_bresp;
        @(posedge clock);
        if (ta) s_axi_awvalid <= 1'b0;
        if (tw) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      chk({30'h0, r}, {30'h0, er});
    end
  endtask

  task rd(input [11:0] a, input [7:0] e, input [1:0] er);
    reg ta, b;
    reg [1:0] r;
    begin
      @(posedge clock);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      b = 1'b0;
      while (!b) begin
        @(negedge clock);
        ta = s_axi_arvalid && s_axi_arready;
        b = s_axi_rvalid;
        rv = s_axi_rdata;
        r = s_axi_rresp;
        @(posedge clock);
        if (ta) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
      chk(rv, {24'h0, e});
      chk({30'h0, r}, {30'h0, er});
    end
  endtask

  task cfg(input [7:0] c);
    begin
      wr(A_CF, c, OK);
      mux <= !c[`XDM_CFG_MUXSEL];
      grp <= c[`XDM_CFG_PORT_GROUP_SELECT];
    end
  endtask

  // One core move; gathers pin activity until completion
  task acc(input w, input wd, input [15:0] dp, input [7:0] lo, input [7:0] d);
    reg t;
    begin
      @(posedge clock);
      req_valid <= 1'b1;
      req_write <= w;
      req_wide <= wd;
      req_data_pointer <= dp;
      req_low_byte <= lo;
      req_wdata <= d;
      t = 1'b0;
      while (!t) begin
        @(negedge clock);
        t = req_ready;
        @(posedge clock);
      end
      req_valid <= 1'b0;
      cl = 0;
      sl = 0;
      // No strobe seen yet: stale pin values must not satisfy a later check
      hv = 8'h00;
      gm = 2'b11;
      al = 0;
      hen = 0;
      t = 1'b0;
      while (!t) begin
        @(negedge clock);
        if (ctl_oe_n != 2'b11) cl = cl + 1;
        if (pin_ale) al = al + 1;
        if (addr_hi_oe_n != 2'b11) hen = 1;
        if (!pin_rd_n || !pin_wr_n) begin
          sl = sl + 1;
          hv = pin_addr_hi;
          gm = ctl_oe_n;
        end
        t = resp_valid;
      end
      rv = {24'h0, resp_rdata};
    end
  endtask

  task t_regs;
    begin
      rd(A_TC, `XDM_RST_TIMING, OK);
      rd(A_PG, `XDM_RST_PAGE, OK);
      rd(A_CF, {2'b00, `XDM_RST_CONFIG}, OK);
      wr(A_CF, 8'hff, OK);
      rd(A_CF, 8'h3f, OK);
      wr(12'h000, 8'h11, ER);
      rd(12'h000, 8'h00, ER);
      $display("test regs done");
    end
  endtask

  task t_int;
    begin
      cfg(8'h10);
      acc(1'b1, 1'b1, 16'h1234, 8'h00, 8'h5a);
      chk(cl, 0);
      wr(A_PG, 8'h22, OK);
      acc(1'b0, 1'b0, 16'h0000, 8'h34, 8'h00);
      chk(rv, 32'h5a);
      chk(cl, 0);
      $display("test internal done");
    end
  endtask

  task t_split;
    begin
      wr(A_TC, 8'h00, OK);
      cfg(8'h14);
      wr(A_PG, 8'h0f, OK);
      acc(1'b1, 1'b0, 16'h0000, 8'h80, 8'h3c);
      chk(cl, 0);
      wr(A_PG, 8'h30, OK);
      acc(1'b1, 1'b0, 16'h0000, 8'h11, 8'hc3);
      chk(cl, 5);
      chk(hen, 0);
      acc(1'b1, 1'b1, 16'h5022, 8'h00, 8'h5a);
      chk(hv, 8'h50);
      chk(hen, 1);
      cfg(8'h18);
      acc(1'b1, 1'b0, 16'h0000, 8'h11, 8'h66);
      chk(hv, 8'h30);
      acc(1'b0, 1'b1, 16'h3011, 8'h00, 8'h00);
      chk(rv, 32'h66);
      chk(hv, 8'h30);
      acc(1'b0, 1'b1, 16'hff11, 8'h00, 8'h00);
      chk(rv, 32'hc3);
      acc(1'b0, 1'b1, 16'h0fff, 8'h00, 8'h00);
      chk(cl, 0);
      $display("test split done");
    end
  endtask

  task t_ext;
    begin
      cfg(8'h3c);
      wr(A_PG, 8'h12, OK);
      acc(1'b1, 1'b0, 16'h0000, 8'h05, 8'h99);
      chk(hen, 0);
      chk(gm, 2'b01);
      // Status: last was an off-chip write, pins already released
      rd(A_ST, 8'h06, OK);
      acc(1'b1, 1'b1, 16'h0005, 8'h00, 8'h77);
      chk(cl, 5);
      acc(1'b0, 1'b1, 16'hff05, 8'h00, 8'h00);
      chk(rv, 32'h99);
      acc(1'b0, 1'b1, 16'h0005, 8'h00, 8'h00);
      chk(rv, 32'h77);
      $display("test external done");
    end
  endtask

  task t_mux;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        wc = 4'h5 * k[3:0];
        wr(A_TC, {k[1:0], wc, 2'd3 - k[1:0]}, OK);
        cfg(8'h0c | k[7:0]);
        acc(1'b1, 1'b1, {8'h80, k[7:0]}, 8'h00, 8'h40 + k[7:0]);
        chk(cl, 3 + wc + 1 + 4 + 2 * (k + 1));
        chk(al, k + 1);
        chk(sl, wc + 1);
        acc(1'b0, 1'b1, {8'h80, k[7:0]}, 8'h00, 8'h00);
        chk(rv, 32'h40 + k);
      end
      $display("test mux done");
    end
  endtask

  initial begin
    sys_rst = 1'b1;
    {mux, grp, req_valid, req_write, req_wide} = 5'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
    {req_data_pointer, req_low_byte, req_wdata} = 32'h0;
    s_axi_wstrb = 4'hf;
    bad_count = 0;
    check_count = 0;
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    t_regs;
    t_int;
    t_split;
    t_ext;
    t_mux;
    results;
  end

  // Whole run needs well under a thousand cycles
  initial begin
    #500000;
    bad_count = bad_count + 1;
    results;
  end
endmodule // xdm_mem_if_tb

/* xdm_sram_model.sv */
// Behavioural off-chip SRAM behind a transparent address latch
`timescale 1ns/10ps
module xdm_sram_model (
  input  wire       clock,
  input  wire       mux,
  input  wire       grp,
  input  wire       pin_ale,
  input  wire       pin_rd_n,
  input  wire       pin_wr_n,
  input  wire [7:0] pin_addr_hi,
  input  wire [7:0] pin_addr_lo,
  input  wire [7:0] pin_data_out,
  input  wire [1:0] addr_hi_oe_n,
  output wire [7:0] pin_data_in_lo,
  output wire [7:0] pin_data_in_hi
);
  reg  [7:0]  mem [0:65535];
  reg  [7:0]  lat_q;
  reg  [7:0]  junk_q = 8'ha5;
  // Undriven upper lines sit at the parked port latch value
  wire [7:0]  hi = (addr_hi_oe_n == 2'b11) ? 8'hff : pin_addr_hi;
  wire [15:0] a  = {hi, mux ? lat_q : pin_addr_lo};
  wire [7:0]  rd = pin_rd_n ? junk_q : mem[a];
  always @* if (pin_ale) lat_q = pin_data_out;
  always @(posedge clock) begin
    junk_q <= ~junk_q; // Released bus never shows a stale value
    if (!pin_wr_n) mem[a] <= pin_data_out;
  end
  assign pin_data_in_lo = grp ? junk_q : rd;
  assign pin_data_in_hi = grp ? rd : junk_q;
endmodule // xdm_sram_model
